// file: adc_seq_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and the design modules
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// apb byte addresses
`define OFF_CTL2            12'h000
`define OFF_FORMAT          12'h004
`define OFF_START           12'h008
`define OFF_STATUS          12'h00c
`define OFF_COMPARE         12'h010
`define OFF_RESULT_BASE     12'h040

// control-2 fields (trigger)
`define CTL2_TRIG_ENABLE    2
`define CTL2_TRIG_POLARITY  3
`define CTL2_TRIG_LEVEL     4
`define CTL2_RESET          8'h00

// format control fields
`define FMT_JUSTIFY         7
`define FMT_LEN_HI          6
`define FMT_LEN_LO          3
`define FMT_RING            2
`define FMT_FRZ_HI          1
`define FMT_FRZ_LO          0
`define FMT_RESET           8'h20

// start register fields
`define START_SCAN          5

// compare register fields
`define CMP_IRQ_ENABLE      12

// result file
`define RESULT_COUNT        12
`define RESULT_WIDTH        10
`define LEN_MAX             4'hc

// conversion timing: time per conversion in ns, and cycles at 100 ns
`define CONV_TIME_NS        1400
`define CLK_PERIOD_NS       100
`define CONV_CYCLES         ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: adc_seq_pkg.sv
// types for the converter sequencing block
// assumes adc_seq_cfg.svh alongside
`include "adc_seq_cfg.svh"

package adc_seq_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_FROZEN
    } seq_state_type;

    // freeze reaction codes
    typedef enum logic [1:0] {
        FRZ_CONTINUE = 2'b00,
        FRZ_RESERVED = 2'b01,
        FRZ_FINISH   = 2'b10,
        FRZ_NOW      = 2'b11
    } freeze_type;

endpackage : adc_seq_pkg

// file: trigger_detect.sv
// external trigger sensitivity detector
// assumes trigger input is synchronous to clk
`timescale 1ns/1ns

module trigger_detect
    import adc_seq_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic trigger_in,           // external trigger line
    input  wire logic trigger_level_select, // 1 = level sensitive
    input  wire logic trigger_polarity,     // 1 = rising / high
    output logic      trigger_hit           // registered trigger event
);

    logic trigger_last_reg; // previous trigger sample

    ////////////////////////////////////////////////////////////////////////////
    // previous sample for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trigger_last_reg <= 1'b0;
        end else begin
            trigger_last_reg <= trigger_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // four sensitivity combinations
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trigger_hit <= 1'b0;
        end else begin
            unique case ({trigger_level_select, trigger_polarity})
                2'b00: trigger_hit <= trigger_last_reg & ~trigger_in;
                2'b01: trigger_hit <= ~trigger_last_reg & trigger_in;
                2'b10: trigger_hit <= ~trigger_in;
                2'b11: trigger_hit <= trigger_in;
            endcase
        end
    end

endmodule : trigger_detect

// file: adc_sequence_format_control.sv
// converter sequencing and result-format control with apb registers
// assumes an apb master on clk, a converter core that answers conv_done
// with conv_data, and a synchronous trigger and freeze request
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"

module adc_sequence_format_control
    import adc_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        trigger_in,
    input  wire logic        freeze_req,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_data,
    output logic             conv_start,
    output logic             seq_active,
    output logic             seq_complete,
    output logic             compare_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0]  ctl2_reg;                       // trigger control
    logic [7:0]  sequence_format_control;        // format control
    logic [7:0]  start_reg;                      // sequence start
    logic [12:0] compare_reg;                    // per-conv enables + irq enable
    logic [15:0] result_mem [`RESULT_COUNT];     // result file
    logic [3:0]  result_slot_counter;            // next result slot
    logic [3:0]  conv_count_reg;                 // conversions done in sequence
    logic        armed_reg;                      // start written, trigger allowed
    logic        finish_freeze_reg;              // freeze after current conversion
    seq_state_type state_reg;                    // sequencer state
    logic        trigger_hit;                    // trigger event
    logic        fmt_write;                      // format register write
    logic        start_write;                    // start register write
    logic        abort;                          // any abort
    logic        conv_end;                       // conversion finishing
    logic [3:0]  seq_len;                        // decoded length
    logic        ring_mode;                      // ring placement
    logic [15:0] justified;                      // formatted result
    logic        scan_mode;                      // continuous sequences
    logic        frozen_now;                     // freeze holds progress

    // length decode, used for sequence end and status
    function automatic logic [3:0] decode_len(input logic [3:0] code);
        if (code == 4'h0 || code > 4'hb) begin
            decode_len = `LEN_MAX;
        end else begin
            decode_len = code;
        end
    endfunction : decode_len

    // apb access qualifier, used for several registers
    function automatic logic bus_write(input logic [11:0] addr, input logic [11:0] off);
        bus_write = psel && penable && pwrite && (addr == off);
    endfunction : bus_write

    assign fmt_write   = bus_write(paddr, `OFF_FORMAT);
    assign start_write = bus_write(paddr, `OFF_START);
    assign abort       = fmt_write || bus_write(paddr, `OFF_CTL2) || start_write;
    assign seq_len     = decode_len(sequence_format_control[`FMT_LEN_HI:`FMT_LEN_LO]);
    assign ring_mode   = sequence_format_control[`FMT_RING];
    assign scan_mode   = start_reg[`START_SCAN] && !ctl2_reg[`CTL2_TRIG_ENABLE];
    assign conv_end    = (state_reg == SEQ_CONVERT) && conv_done && !frozen_now;

    // freeze reaction
    always_comb begin
        unique case (freeze_type'(sequence_format_control[`FMT_FRZ_HI:`FMT_FRZ_LO]))
            FRZ_NOW:  frozen_now = freeze_req;
            default:  frozen_now = 1'b0;            // continue, finish handled apart
        endcase
    end

    // justification: left puts msb at bit 15
    always_comb begin
        if (sequence_format_control[`FMT_JUSTIFY]) begin
            justified = {6'h00, conv_data};
        end else begin
            justified = {conv_data, 6'h00};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger sensing on control-2 bits
    trigger_detect u_trigger (
        .clk                  (clk),
        .rst_n                (rst_n),
        .trigger_in           (trigger_in),
        .trigger_level_select (ctl2_reg[`CTL2_TRIG_LEVEL]),
        .trigger_polarity     (ctl2_reg[`CTL2_TRIG_POLARITY]),
        .trigger_hit          (trigger_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl2_reg                <= `CTL2_RESET;
            sequence_format_control <= `FMT_RESET;
            start_reg               <= 8'h00;
            compare_reg             <= 13'h0000;
        end else begin
            if (bus_write(paddr, `OFF_CTL2)) begin
                ctl2_reg <= pwdata[7:0];
            end
            if (fmt_write) begin
                sequence_format_control <= pwdata[7:0];
            end
            if (start_write) begin
                start_reg <= pwdata[7:0];
            end
            if (bus_write(paddr, `OFF_COMPARE)) begin
                compare_reg <= pwdata[12:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer state machine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg         <= SEQ_IDLE;
            armed_reg         <= 1'b0;
            finish_freeze_reg <= 1'b0;
            conv_count_reg    <= 4'h0;
        end else if (abort) begin
            // start write restarts, other writes just stop
            state_reg         <= SEQ_IDLE;
            armed_reg         <= start_write;
            finish_freeze_reg <= 1'b0;
            conv_count_reg    <= 4'h0;
        end else begin
            unique case (state_reg)
                SEQ_IDLE: begin
                    // a leftover finish request would freeze a triggered restart
                    finish_freeze_reg <= 1'b0;
                    if (armed_reg && (!ctl2_reg[`CTL2_TRIG_ENABLE] || trigger_hit)) begin
                        state_reg      <= SEQ_CONVERT;
                        conv_count_reg <= 4'h0;
                        armed_reg      <= ctl2_reg[`CTL2_TRIG_ENABLE];
                    end
                end
                SEQ_CONVERT: begin
                    if (freeze_req && sequence_format_control[`FMT_FRZ_HI]
                        && !sequence_format_control[`FMT_FRZ_LO]) begin
                        finish_freeze_reg <= 1'b1;
                    end
                    if (frozen_now) begin
                        state_reg <= SEQ_FROZEN;
                    end else if (conv_end) begin
                        if (finish_freeze_reg || (freeze_req && sequence_format_control[`FMT_FRZ_HI])) begin
                            state_reg <= SEQ_FROZEN;
                        end
                        if (conv_count_reg + 4'h1 >= seq_len) begin
                            conv_count_reg <= 4'h0;
                            if (!scan_mode) begin
                                state_reg <= SEQ_IDLE;
                            end
                        end else begin
                            conv_count_reg <= conv_count_reg + 4'h1;
                        end
                    end
                end
                SEQ_FROZEN: begin
                    if (!freeze_req) begin
                        state_reg         <= SEQ_CONVERT;
                        finish_freeze_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result slot counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_slot_counter <= 4'h0;
        end else if (abort) begin
            result_slot_counter <= 4'h0;
        end else if (state_reg == SEQ_IDLE && armed_reg && !ring_mode
                     && (!ctl2_reg[`CTL2_TRIG_ENABLE] || trigger_hit)) begin
            result_slot_counter <= 4'h0;
        end else if (conv_end) begin
            if (!ring_mode && conv_count_reg + 4'h1 >= seq_len) begin
                result_slot_counter <= 4'h0;
            end else if (result_slot_counter == `LEN_MAX - 4'h1) begin
                result_slot_counter <= 4'h0;
            end else begin
                result_slot_counter <= result_slot_counter + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result file write
    always_ff @(posedge clk) begin
        if (conv_end) begin
            result_mem[result_slot_counter] <= justified;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter strobes and compare event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_start   <= 1'b0;
            seq_active   <= 1'b0;
            seq_complete <= 1'b0;
            compare_irq  <= 1'b0;
        end else begin
            conv_start   <= !abort && (state_reg == SEQ_IDLE) && armed_reg
                            && (!ctl2_reg[`CTL2_TRIG_ENABLE] || trigger_hit);
            seq_active   <= state_reg != SEQ_IDLE;
            seq_complete <= conv_end && !abort && (conv_count_reg + 4'h1 >= seq_len);
            // compare result flag; ring mode masks the flag and leaves the enables unchanged
            compare_irq  <= conv_end && !abort && !ring_mode
                            && compare_reg[`CMP_IRQ_ENABLE]
                            && compare_reg[conv_count_reg];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, unmapped reads zero with error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == `OFF_CTL2) begin
                    prdata <= {24'h000000, ctl2_reg};
                end else if (paddr == `OFF_FORMAT) begin
                    prdata <= {24'h000000, sequence_format_control};
                end else if (paddr == `OFF_START) begin
                    prdata <= {24'h000000, start_reg};
                end else if (paddr == `OFF_STATUS) begin
                    prdata <= {16'h0000, seq_len, 3'h0, state_reg != SEQ_IDLE,
                               4'h0, result_slot_counter};
                end else if (paddr == `OFF_COMPARE) begin
                    prdata <= {19'h00000, compare_reg};
                end else if (paddr >= `OFF_RESULT_BASE
                             && paddr < `OFF_RESULT_BASE + 12'h030 && paddr[1:0] == 2'b00) begin
                    prdata <= {16'h0000, result_mem[4'(paddr[5:2])]};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule : adc_sequence_format_control

// file: adc_seq_chk.sv
// port checker for the sequencing and format block
// assumes it is bound to adc_sequence_format_control
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"

module adc_seq_chk
    import adc_seq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        freeze_req,
    input wire logic        conv_done,
    input wire logic        conv_start,
    input wire logic        seq_active,
    input wire logic        seq_complete,
    input wire logic        compare_irq
);
    logic [7:0] fmt_reg;  // shadow of the format register
    logic       trig_reg; // shadow of trigger enable
    logic [3:0] cnt_reg;  // results taken since the start
    logic       wr;       // write completes at this edge
    assign wr = psel && penable && pready && pwrite;

    // decoded sequence length
    function automatic logic [3:0] dec(input logic [3:0] c);
        return (c == 4'h0 || c > 4'hb) ? 4'hc : c;
    endfunction : dec

    ////////////////////////////////////////////////////////////////////////
    // shadows follow completed writes only
    always_ff @(posedge clk) begin
        if (!rst_n)
            fmt_reg <= `FMT_RESET;
        else if (wr && paddr == `OFF_FORMAT)
            fmt_reg <= pwdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            trig_reg <= 1'b0;
        else if (wr && paddr == `OFF_CTL2)
            trig_reg <= pwdata[`CTL2_TRIG_ENABLE];
    end

    // frozen results are not counted, they are not taken;
    // a result seen with the start pulse is the first of the new sequence
    always_ff @(posedge clk) begin
        if (!rst_n || (wr && paddr <= `OFF_START))
            cnt_reg <= 4'h0;
        else if (conv_start || seq_complete)
            cnt_reg <= {3'h0, conv_done && !(freeze_req && fmt_reg[1:0] == 2'b11)};
        else if (conv_done && !(freeze_req && fmt_reg[1:0] == 2'b11))
            cnt_reg <= cnt_reg + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_unmapped_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response with data");
    a_abort_write: assert property (wr && paddr == `OFF_FORMAT |-> ##[1:2] !seq_active)
        else $error("format write did not abort");
    a_start_write: assert property (wr && paddr == `OFF_START && !trig_reg |-> ##[1:2] conv_start)
        else $error("start write did not start");
    a_ring_no_cmp: assert property (fmt_reg[`FMT_RING] && $past(fmt_reg[`FMT_RING]) |-> !compare_irq)
        else $error("compare in ring mode");
    a_done_before_end: assert property (seq_complete |-> $past(conv_done) || $past(conv_done, 2))
        else $error("end without result");
    a_len_count: assert property (seq_complete |-> cnt_reg == dec(fmt_reg[6:3]))
        else $error("wrong sequence length");
    a_freeze_now: assert property ($past(freeze_req) && $past(fmt_reg[1:0]) == 2'b11 |-> !seq_complete)
        else $error("sequence ended while frozen");

    c_complete: cover property (seq_complete);
    c_ring_end: cover property (fmt_reg[`FMT_RING] && seq_complete);
    c_refused: cover property (pslverr);
endmodule : adc_seq_chk

bind adc_sequence_format_control adc_seq_chk u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .freeze_req(freeze_req), .conv_done(conv_done),
    .conv_start(conv_start), .seq_active(seq_active),
    .seq_complete(seq_complete), .compare_irq(compare_irq));

// file: tb_adc_sequence_format_control.sv
// self-checking bench for the sequencing and format block
// assumes the apb slave answers within fifteen wait states
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"

module tb_adc_sequence_format_control
    import adc_seq_pkg::*;
;
    logic        clk, rst_n, psel, penable, pwrite;
    logic        trigger_in, freeze_req, conv_done, perr;
    logic        pready, pslverr, conv_start, seq_active;
    logic        seq_complete, compare_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  conv_data;
    int          err_count = 0, check_count = 0;
    int          n_cpl = 0, n_start = 0, n_cmp = 0, s0, c0;

    adc_sequence_format_control DUT (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .trigger_in(trigger_in),
        .freeze_req(freeze_req), .conv_done(conv_done), .conv_data(conv_data),
        .conv_start(conv_start), .seq_active(seq_active),
        .seq_complete(seq_complete), .compare_irq(compare_irq));

    always #50 clk = ~clk;

    // pulse tallies, updated late so readers never race them
    always @(posedge clk) begin
        if (seq_complete === 1'b1) n_cpl <= n_cpl + 1;
        if (conv_start === 1'b1) n_start <= n_start + 1;
        if (compare_irq === 1'b1) n_cmp <= n_cmp + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task results;
        $display("errors=%0d checks=%0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    // one apb transfer plus an idle cycle, so calls never collide
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (n == 16) begin
            err_count++;
            results();
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask : rdc

    // one result from the converter core, then a pause
    task done(input logic [9:0] d);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : done

    ////////////////////////////////////////////////////////////////////////
    task t_len;
        int e;
        rdc(`OFF_FORMAT, 32'hff, 32'h20);
        for (int c = 0; c < 16; c++) begin
            e = (c == 0 || c > 11) ? 12 : c;
            wr(`OFF_FORMAT, 32'(c << 3));
            rdc(`OFF_STATUS, 32'hf000, 32'(e << 12));
        end
    endtask : t_len

    task t_plain;
        wr(`OFF_FORMAT, 32'h98);
        wr(`OFF_COMPARE, 32'h1fff);
        s0 = n_cmp;
        c0 = n_cpl;
        wr(`OFF_START, 32'h0);
        done(10'h3ff);
        done(10'h155);
        done(10'h001);
        check(32'(n_cpl - c0), 32'h1);
        check(32'(n_cmp - s0), 32'h3);
        rdc(`OFF_RESULT_BASE, 32'hffff, 32'h3ff);
        rdc(`OFF_RESULT_BASE + 12'h4, 32'hffff, 32'h155);
        rdc(`OFF_RESULT_BASE + 12'h8, 32'hffff, 32'h001);
        wr(`OFF_FORMAT, 32'h08);
        wr(`OFF_START, 32'h0);
        done(10'h2aa);
        rdc(`OFF_RESULT_BASE, 32'hffff, 32'haa80);
    endtask : t_plain

    // ring mode, length five, scanning: thirteen results wrap once
    task t_ring;
        wr(`OFF_COMPARE, 32'h1fff);
        c0 = n_cmp;
        wr(`OFF_FORMAT, 32'hac);
        wr(`OFF_START, 32'h20);
        for (int i = 1; i <= 13; i++) done(10'(12'h100 + i));
        rdc(`OFF_STATUS, 32'hf, 32'h1);
        rdc(`OFF_RESULT_BASE, 32'hffff, 32'h10d);
        rdc(`OFF_RESULT_BASE + 12'h2c, 32'hffff, 32'h10c);
        check(32'(n_cmp - c0), 32'h0);
        wr(`OFF_FORMAT, 32'hac);
        rdc(`OFF_STATUS, 32'h10f, 32'h0);
        wr(`OFF_START, 32'h0);
        done(10'h001);
        wr(`OFF_START, 32'h0);
        rdc(`OFF_STATUS, 32'hf, 32'h0);
        done(10'h03c);
        rdc(`OFF_RESULT_BASE, 32'hffff, 32'h03c);
        wr(`OFF_COMPARE, 32'h0);
    endtask : t_ring

    // idle level is the inverse of the polarity bit in all four modes
    task t_trig;
        for (int m = 0; m < 4; m++) begin
            trigger_in <= ~m[0];
            wr(`OFF_CTL2, 32'(m << 3) | 32'h4);
            s0 = n_start;
            wr(`OFF_START, 32'h0);
            repeat (4) @(posedge clk);
            check(32'(n_start - s0), 32'h0);
            trigger_in <= m[0];
            repeat (4) @(posedge clk);
            check(32'(n_start != s0), 32'h1);
            wr(`OFF_CTL2, 32'h0);
        end
    endtask : t_trig

    // every freeze code, with freeze requested before the result arrives
    task t_freeze;
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_FORMAT, 32'(8 | c));
            c0 = n_cpl;
            wr(`OFF_START, 32'h0);
            freeze_req <= 1'b1;
            @(posedge clk);
            done(10'h055);
            check(32'(n_cpl - c0), 32'(c != 3));
            freeze_req <= 1'b0;
            @(posedge clk);
            if (c == 3) done(10'h055);
            check(32'(n_cpl - c0), 32'h1);
        end
    endtask : t_freeze

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        rst_n = 0;
        {psel, penable, pwrite, trigger_in, freeze_req, conv_done} = '0;
        paddr = '0;
        pwdata = '0;
        conv_data = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_len();
        t_plain();
        t_ring();
        t_trig();
        t_freeze();
        apb(1'b0, 12'hffc, 32'h0);
        check(rd, 32'h0);
        check({31'h0, perr}, 32'h1);
        results();
    end
endmodule : tb_adc_sequence_format_control
